// File: design/spcd_pkg.sv
// Constants and carriers for the spindle power command decoder
// Notes on behaviour
// RL1 - Opcode 1Bh is the spindle command
// RL2 - Early-status clear: status after operation finishes; code waits only for code 0h and flush
// RL3 - Early-status set: Good status at once
// RL4 - Nonzero power code ignores start bit
// RL5 - Decode active, idle a/b/c, standby z/y
// RL6 - Code 7h returns control to timers
// RL7 - Codes Ah/Bh force chosen timer zero
// RL8 - Move to requested power condition
// RL9 - Explicit request disables timers until handback
// RL10 - No dwell or unload caps under initiator
// RL11 - Handback starts supported, enabled timers
// RL12 - Conflicting handback note; follow previous rule
// RL13 - Force: zero timer, enter condition, handback
// RL14 - Force on unsupported/inactive timer is illegal
// RL15 - Requesting current condition is no error
// RL16 - Initiator keeps load_eject_bit zero
// RL17 - Spindle command accepted whether motor stopped
// RL18 - Opcode 35h is cache flush
// RL19 - Flush start block from bytes 2-5
// RL20 - Flush with early-status set is illegal
// RL21 - Flush length bytes 7-8; zero means rest
// RL22 - Not ready answers before startup completes; code exempts opcodes 00h, 12h and 03h
// RL23 - Reserved codes or modifiers are illegal
// RL24 - Field positions: byte4 hi, byte3 lo, bit0
package spcd_pkg;
  localparam logic [7:0] OP_SPINDLE = 8'h1B;
  localparam logic [7:0] OP_FLUSH = 8'h35;
  localparam logic [7:0] OP_TUR = 8'h00;
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  localparam logic [7:0] OP_REQ_SENSE = 8'h03;
  localparam logic [3:0] PC_START = 4'h0;
  localparam logic [3:0] PC_ACTIVE = 4'h1;
  localparam logic [3:0] PC_IDLE = 4'h2;
  localparam logic [3:0] PC_STANDBY = 4'h3;
  localparam logic [3:0] PC_UNIT = 4'h7;
  localparam logic [3:0] PC_FORCE_IDLE = 4'hA;
  localparam logic [3:0] PC_FORCE_STBY = 4'hB;
  localparam logic [3:0] MOD_0 = 4'h0;
  localparam logic [3:0] MOD_1 = 4'h1;
  localparam logic [3:0] MOD_2 = 4'h2;
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_NOT_READY = 4'h2;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_INVALID_CDB = 8'h24;
  localparam logic [7:0] ASC_BECOMING_READY = 8'h04;
  localparam logic [7:0] ASCQ_BECOMING_READY = 8'h01;
  localparam int TIMER_N = 5;
  // Power conditions, one per supported state
  typedef enum logic [2:0] {
    SPCD_ACTIVE, SPCD_IDLE_A, SPCD_IDLE_B, SPCD_IDLE_C, SPCD_STBY_Z, SPCD_STBY_Y
  } spcd_power_e;
  typedef struct packed {
    logic [7:0] opcode;
    logic early;
    logic [31:0] lba;
    logic [3:0] modifier;
    logic [3:0] power_code;
    logic load_eject_bit;
    logic start;
    logic [15:0] length;
  } spcd_cdb_s;
  typedef struct packed {
    logic good;
    logic [3:0] sense_key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } spcd_status_s;
  typedef struct packed {
    logic [31:0] lba;
    logic [15:0] count;
    logic to_end;
  } spcd_flush_s;
endpackage

// File: design/spcd_decoder.sv
// Spindle power and cache flush command decoder
module spcd_decoder (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire logic [79:0] i_cdb,
  input wire logic i_ready_done,
  input wire logic [4:0] i_timer_supported,
  input wire logic [4:0] i_timer_enabled,
  input wire logic i_op_done,
  output logic o_busy,
  output logic o_status_valid,
  output spcd_pkg::spcd_status_s o_status,
  output logic o_spin_req,
  output logic o_spin_start,
  output logic o_power_req,
  output spcd_pkg::spcd_power_e o_power,
  output logic o_unit_timer_control,
  output logic [4:0] o_timer_running,
  output logic [4:0] o_timer_zero,
  output logic o_limits_enforced,
  output logic o_flush_req,
  output spcd_pkg::spcd_flush_s o_flush
);
  import spcd_pkg::*;

  typedef enum logic [1:0] {SPCD_IDLE_ST, SPCD_WAIT_ST} spcd_state_e;
  spcd_state_e state;
  spcd_status_s next_status;
  spcd_cdb_s cdb;

  // RL24 field positions
  assign cdb.opcode = i_cdb[79:72];
  assign cdb.early = i_cdb[64];
  assign cdb.lba = i_cdb[63:32];
  assign cdb.modifier = i_cdb[51:48];
  assign cdb.power_code = i_cdb[47:44];
  assign cdb.load_eject_bit = i_cdb[41];
  assign cdb.start = i_cdb[40];
  assign cdb.length = i_cdb[23:8];

  function automatic spcd_status_s mk_status(input logic [3:0] key, input logic [7:0] asc, input logic [7:0] ascq);
    mk_status = '{good: (key == SK_NONE), sense_key: key, asc: asc, ascq: ascq};
  endfunction

  wire take = i_cmd_valid && (state == SPCD_IDLE_ST);
  // RL1 spindle opcode
  wire is_spin = cdb.opcode == OP_SPINDLE;
  // RL18 flush opcode
  wire is_flush = cdb.opcode == OP_FLUSH;
  wire always_ok = cdb.opcode == OP_TUR || cdb.opcode == OP_INQUIRY || cdb.opcode == OP_REQ_SENSE;
  // RL22 not ready before startup
  wire not_ready = !i_ready_done && !always_ok;
  // RL5 power condition decode
  wire pc_start = cdb.power_code == PC_START && cdb.modifier == MOD_0;
  wire pc_active = cdb.power_code == PC_ACTIVE && cdb.modifier == MOD_0;
  wire pc_idle = cdb.power_code == PC_IDLE && cdb.modifier <= MOD_2;
  wire pc_stby = cdb.power_code == PC_STANDBY && cdb.modifier <= MOD_1;
  // RL6 unit control
  wire pc_unit = cdb.power_code == PC_UNIT && cdb.modifier == MOD_0;
  // RL7 force timer decode
  wire pc_fidle = cdb.power_code == PC_FORCE_IDLE && cdb.modifier <= MOD_2;
  wire pc_fstby = cdb.power_code == PC_FORCE_STBY && cdb.modifier <= MOD_1;
  // Standby selections sit above the three idle timers and conditions
  wire stby_sel = pc_fstby || pc_stby;
  wire [2:0] tsel = stby_sel ? 3'(cdb.modifier) + 3'h3 : 3'(cdb.modifier);
  wire [4:0] tmask = 5'h01 << tsel;
  wire pc_force = pc_fidle || pc_fstby;
  // RL14 force needs supported and running timer
  wire force_bad = pc_force && ((tmask & i_timer_supported & o_timer_running) == 5'h00);
  // RL23 reserved codes rejected
  wire pc_legal = pc_start || pc_active || pc_idle || pc_stby || pc_unit || pc_force;
  wire spin_bad = !pc_legal || force_bad;
  // RL20 flush with early status rejected
  wire flush_bad = cdb.early;
  wire pc_set = pc_active || pc_idle || pc_stby;
  spcd_power_e req_power;
  assign req_power = pc_active ? SPCD_ACTIVE : spcd_power_e'(tsel + 3'h1);
  // RL17 RL15 accepted in any motor or power state
  wire accept_spin = take && is_spin && !not_ready && !spin_bad;
  wire accept_flush = take && is_flush && !not_ready && !flush_bad;
  // RL4 start bit only used with code 0h
  wire do_spin = accept_spin && pc_start;
  // RL2 RL3 start code waits unless early status; flush always waits
  wire need_wait = (do_spin && !cdb.early) || accept_flush;

  always_comb begin
    next_status = mk_status(SK_NONE, ASC_NONE, ASC_NONE);
    if (not_ready) begin
      next_status = mk_status(SK_NOT_READY, ASC_BECOMING_READY, ASCQ_BECOMING_READY);
    end else if ((is_spin && spin_bad) || (is_flush && flush_bad)) begin
      next_status = mk_status(SK_ILLEGAL, ASC_INVALID_CDB, ASC_NONE);
    end
  end

  assign o_busy = state == SPCD_WAIT_ST;
  // RL10 limits only under unit control
  assign o_limits_enforced = o_unit_timer_control;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state <= SPCD_IDLE_ST;
      o_status_valid <= 1'b0;
      o_status <= '0;
      o_spin_req <= 1'b0;
      o_spin_start <= 1'b0;
      o_power_req <= 1'b0;
      o_power <= SPCD_ACTIVE;
      o_unit_timer_control <= 1'b1;
      o_timer_running <= 5'h1F;
      o_timer_zero <= 5'h00;
      o_flush_req <= 1'b0;
      o_flush <= '0;
    end else begin
      o_status_valid <= 1'b0;
      o_spin_req <= do_spin;
      o_power_req <= 1'b0;
      o_timer_zero <= 5'h00;
      o_flush_req <= accept_flush;
      if (state == SPCD_WAIT_ST && i_op_done) begin
        state <= SPCD_IDLE_ST;
        o_status_valid <= 1'b1;
        o_status <= mk_status(SK_NONE, ASC_NONE, ASC_NONE);
      end
      if (take) begin
        if (need_wait) begin
          state <= SPCD_WAIT_ST;
        end else begin
          o_status_valid <= 1'b1;
          o_status <= next_status;
        end
      end
      if (do_spin) begin
        o_spin_start <= cdb.start;
      end
      // RL8 RL9 explicit condition, timers stopped
      if (accept_spin && pc_set) begin
        o_power_req <= 1'b1;
        o_power <= req_power;
        o_unit_timer_control <= 1'b0;
        o_timer_running <= 5'h00;
      end
      // RL11 RL12 handback starts enabled timers
      if (accept_spin && pc_unit) begin
        o_unit_timer_control <= 1'b1;
        o_timer_running <= i_timer_supported & i_timer_enabled;
      end
      // RL13 force timer to zero
      if (accept_spin && pc_force) begin
        o_timer_zero <= tmask;
        o_power_req <= 1'b1;
        o_power <= req_power;
        o_unit_timer_control <= 1'b1;
      end
      // RL19 RL21 flush range
      if (accept_flush) begin
        o_flush <= '{lba: cdb.lba, count: cdb.length, to_end: cdb.length == 16'h0000};
      end
    end
  end

  // RL3
  early_good_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (take && is_spin && cdb.early && !not_ready && !spin_bad) |=> o_status_valid && o_status.good) else $error("early status missing");
  // RL2
  late_status_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (do_spin && !cdb.early) |=> !o_status_valid && o_busy) else $error("status too early");
  // RL14
  force_reject_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (take && is_spin && !not_ready && force_bad) |=> o_status_valid && o_status.sense_key == SK_ILLEGAL) else $error("bad force accepted");
  // RL20
  flush_immed_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (take && is_flush && cdb.early && i_ready_done) |=> o_status.asc == ASC_INVALID_CDB && !o_flush_req) else $error("flush early not rejected");
  // RL22
  not_ready_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (take && not_ready) |=> o_status.sense_key == SK_NOT_READY && !o_spin_req) else $error("not ready missed");
  // RL9
  timers_off_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (accept_spin && pc_set) |=> o_timer_running == 5'h00 && !o_unit_timer_control) else $error("timers not disabled");
  // RL11
  unit_ctrl_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (accept_spin && pc_unit) |=> o_unit_timer_control && o_timer_running == $past(i_timer_supported & i_timer_enabled)) else $error("handback wrong");
  // RL21
  flush_all_a: assert property (@(posedge i_clock) disable iff (i_reset)
    accept_flush |=> o_flush_req && o_flush.to_end == (o_flush.count == 16'h0000)) else $error("flush range wrong");
  // RL4
  start_ignored_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (accept_spin && !pc_start) |=> !o_spin_req) else $error("start bit not ignored");

  // RL8
  power_move_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL8
    (accept_spin && pc_set) |=> o_power_req && o_power == $past(req_power))
    else $error("power condition not entered");

  // RL5
  stby_power_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL5
    (accept_spin && pc_stby) |=>
    o_power == (($past(cdb.modifier) == MOD_0) ? SPCD_STBY_Z : SPCD_STBY_Y))
    else $error("standby condition wrong");

  // RL5
  idle_power_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL5
    (accept_spin && pc_idle && cdb.modifier == MOD_0) |=> o_power == SPCD_IDLE_A)
    else $error("idle condition wrong");

  // RL13
  force_zero_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL13
    (accept_spin && pc_force) |=> o_timer_zero == $past(tmask) && o_unit_timer_control && o_power_req)
    else $error("force timer not applied");

  // RL23
  reserved_code_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL23
    (take && is_spin && !not_ready && !pc_legal) |=> o_status_valid && o_status.sense_key == SK_ILLEGAL)
    else $error("reserved code accepted");

  // RL20
  flush_wait_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL20
    accept_flush |=> o_busy && !o_status_valid)
    else $error("flush status too early");

  // RL2
  done_status_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL2
    (o_busy && i_op_done) |=> o_status_valid && o_status.good && !o_busy)
    else $error("completion status missing");

  // RL10
  limits_off_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL10
    (accept_spin && pc_set) |=> !o_limits_enforced)
    else $error("limits still enforced");

  // RL1
  spin_start_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL1
    (accept_spin && pc_start) |=> o_spin_req && o_spin_start == $past(cdb.start))
    else $error("spindle request wrong");

  // RL19
  flush_lba_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL19
    accept_flush |=> o_flush.lba == $past(cdb.lba) && o_flush.count == $past(cdb.length))
    else $error("flush start wrong");

  // RL15
  same_power_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL15
    (accept_spin && pc_set && req_power == o_power) |=> o_status_valid && o_status.good)
    else $error("current condition refused");

  // RL18
  flush_req_a: assert property (@(posedge i_clock) disable iff (i_reset) // RL18
    accept_flush |=> o_flush_req)
    else $error("flush not requested");
endmodule

// File: bench/spcd_op_model.sv
// Spindle and flush operation model that answers each request with a completion pulse
module spcd_op_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_spin_req,
  input wire logic i_flush_req,
  input wire logic [3:0] i_delay,
  output logic o_op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] count;
  logic active;
  // Delay is set per request, so both prompt and slow completions occur
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      count <= 5'h00;
      active <= 1'h0;
      o_op_done <= 1'h0;
    end else begin
      o_op_done <= active && count == 5'h00;
      if (i_spin_req || i_flush_req) begin
        active <= 1'h1;
        count <= {1'h0, i_delay};
      end else if (active && count != 5'h00) begin
        count <= count - 5'h01;
      end else begin
        active <= 1'h0;
      end
    end
  end
endmodule

// File: bench/spcd_decoder_tb.sv
// Self-checking bench for the spindle power command decoder
module spcd_decoder_tb;
  import spcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [20:0] ST_GOOD = {1'h1, SK_NONE, ASC_NONE, 8'h00};
  localparam logic [20:0] ST_BAD = {1'h0, SK_ILLEGAL, ASC_INVALID_CDB, 8'h00};
  localparam logic [20:0] ST_NRDY = {1'h0, SK_NOT_READY, ASC_BECOMING_READY, ASCQ_BECOMING_READY};
  localparam logic [27:0] CODES = 28'h1222331;
  localparam logic [27:0] MODS = 28'h0012010;
  logic i_clock, i_reset, i_cmd_valid, i_ready_done, i_op_done, o_busy, o_status_valid;
  logic o_spin_req, o_spin_start, o_power_req, o_unit_timer_control, o_limits_enforced, o_flush_req;
  logic [79:0] i_cdb;
  logic [4:0] i_timer_supported, i_timer_enabled, o_timer_running, o_timer_zero;
  logic [3:0] op_delay;
  spcd_status_s o_status;
  spcd_power_e o_power;
  spcd_flush_s o_flush;
  int n_mismatch = 0;
  int total_checks = 0;
  spcd_decoder spcd_decoder_inst (.i_clock(i_clock), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
    .i_cdb(i_cdb), .i_ready_done(i_ready_done), .i_timer_supported(i_timer_supported),
    .i_timer_enabled(i_timer_enabled), .i_op_done(i_op_done), .o_busy(o_busy),
    .o_status_valid(o_status_valid), .o_status(o_status), .o_spin_req(o_spin_req),
    .o_spin_start(o_spin_start), .o_power_req(o_power_req), .o_power(o_power),
    .o_unit_timer_control(o_unit_timer_control), .o_timer_running(o_timer_running),
    .o_timer_zero(o_timer_zero), .o_limits_enforced(o_limits_enforced), .o_flush_req(o_flush_req),
    .o_flush(o_flush));
  spcd_op_model spcd_op_model_inst (.i_clock(i_clock), .i_reset(i_reset), .i_spin_req(o_spin_req),
    .i_flush_req(o_flush_req), .i_delay(op_delay), .o_op_done(i_op_done));
  initial begin
    i_clock = 1'h0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Load/eject bit always zero, fields placed in bytes 1, 3 and 4
  function automatic logic [79:0] spin(input logic e, input logic [3:0] m, input logic [3:0] c, input logic s);
    return {OP_SPINDLE, 7'h00, e, 8'h00, 4'h0, m, c, 3'h0, s, 40'h0};
  endfunction
  function automatic logic [79:0] flush(input logic e, input logic [31:0] a, input logic [15:0] n);
    return {OP_FLUSH, 7'h00, e, a, 8'h00, n, 8'h00};
  endfunction
  // Offer one command, then wait a bounded time for its status
  task automatic cmd(input logic [79:0] c, input logic [20:0] st, input logic wt);
    int n;
    @(posedge i_clock);
    i_cmd_valid <= 1'h1;
    i_cdb <= c;
    @(posedge i_clock);
    i_cmd_valid <= 1'h0;
    #1;
    check("busy", 64'(o_busy), 64'(wt));
    n = 0;
    while (o_status_valid !== 1'h1 && n < 40) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check("done", 64'(o_status_valid), 64'h1);
    check("status", 64'(o_status), 64'(st));
  endtask
  initial begin
    #400000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    i_reset = 1'h1;
    i_cmd_valid = 1'h0;
    i_cdb = 80'h0;
    i_ready_done = 1'h0;
    i_timer_supported = 5'h1F;
    i_timer_enabled = 5'h1B;
    op_delay = 4'h2;
    repeat (20) @(posedge i_clock);
    i_reset <= 1'h0;
    cmd(spin(1'h1, MOD_0, PC_ACTIVE, 1'h0), ST_NRDY, 1'h0);
    cmd({OP_TUR, 72'h0}, ST_GOOD, 1'h0);
    i_ready_done <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      cmd(spin(1'h1, MODS[27-4*i -: 4], CODES[27-4*i -: 4], 1'h0), ST_GOOD, 1'h0);
      check("power", 64'(o_power), 64'(i % 6));
      check("power_req", 64'(o_power_req), 64'h1);
    end
    check("running", 64'(o_timer_running), 64'h0);
    check("unit", 64'({o_unit_timer_control, o_limits_enforced}), 64'h0);
    cmd(spin(1'h1, MOD_0, PC_UNIT, 1'h0), ST_GOOD, 1'h0);
    check("running", 64'(o_timer_running), 64'h1B);
    check("unit", 64'({o_unit_timer_control, o_limits_enforced}), 64'h3);
    cmd(spin(1'h1, MOD_1, PC_FORCE_IDLE, 1'h0), ST_GOOD, 1'h0);
    check("zero", 64'(o_timer_zero), 64'h02);
    check("power", 64'(o_power), 64'h2);
    check("unit", 64'(o_unit_timer_control), 64'h1);
    cmd(spin(1'h1, MOD_2, PC_FORCE_IDLE, 1'h0), ST_BAD, 1'h0);
    cmd(spin(1'h1, MOD_0, 4'h4, 1'h0), ST_BAD, 1'h0);
    cmd(spin(1'h1, 4'h3, PC_IDLE, 1'h0), ST_BAD, 1'h0);
    op_delay <= 4'hC;
    cmd(spin(1'h0, MOD_0, PC_START, 1'h1), ST_GOOD, 1'h1);
    check("start", 64'(o_spin_start), 64'h1);
    cmd(spin(1'h0, MOD_0, PC_START, 1'h0), ST_GOOD, 1'h1);
    check("start", 64'(o_spin_start), 64'h0);
    op_delay <= 4'h1;
    cmd(flush(1'h0, 32'h0012_3456, 16'h0000), ST_GOOD, 1'h1);
    check("flush", 64'(o_flush), 64'({32'h0012_3456, 16'h0000, 1'h1}));
    cmd(flush(1'h0, 32'hFFFF_FFF0, 16'h0040), ST_GOOD, 1'h1);
    check("flush", 64'(o_flush), 64'({32'hFFFF_FFF0, 16'h0040, 1'h0}));
    cmd(flush(1'h1, 32'h0000_0010, 16'h0001), ST_BAD, 1'h0);
    end_of_test;
  end
endmodule
